// ===== rtl/wss_sequencer.sv
// Purpose: Programmable waveform sequencer with AHB-Lite register slave
// Assumes: All inputs except arst_n synchronous to mclk; ready inputs already clean
// Notes: One cycle of mclk with clkEn high is one interface clock cycle
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none
`timescale 1ns/100ps
`include "wss_defines.svh"

// Behaviour
// [R1] Seven programmable states 0..6 plus idle state 7.
// [R2] Waveform ends exactly when the program branches into idle.
// [R3] Firmware must not trigger while a waveform still runs.
// [R4] Done flag at bit 7 of idle status and trigger; 1 when idle.
// [R5] Termination optionally raises the waveform-done interrupt.
// [R6] Abort write while running forces return to idle.
// [R7] While busy firmware writes only abort; other writes undefined.
// [R8] Idle data bus floats if idle-drive is 0, else holds last value.
// [R9] Tristate mode bit 7 of control config selects idle control mapping.
// [R10] Mode 0: idle levels [5:0] drive six control outputs, always enabled; the code releases open-drain outputs at level 1.
// [R11] Mode 0: config bit per output, 0 push-pull, 1 open-drain.
// [R12] Mode 1: idle bits [7:4] enable outputs 3..0, [3:0] levels; 4,5 off.
// [R13] Each state is a 32-bit instruction, decision or fixed-duration.
// [R14] Write states drive or float bus; read states sample or not.
// [R15] Fixed-duration state holds outputs for programmed cycle count.
// [R16] All seven fixed-duration: state 6 falls through to idle.
// [R17] Shorter programs must branch to idle explicitly themselves.
// [R18] Decision state samples two terms, combines, branches to one of two.
// [R19] Control task once on entry; self-loop repeats it if re-execute set.
// [R20] Terms: six ready inputs, fifo flag, internal ready, count expired; count expired takes the slot of ready input 5.
// [R21] Combining function is AND, OR or XOR.
// [R22] Decision state lasts at least one cycle; branch on next edge.
// [R23] Transitions only on rising clock edge; states may last long.
// [R24] Duration zero means 256 cycles.
// [R25] After reset idle with done reading 1.
module wss_sequencer #(
	parameter int DATA_WIDTH = 16,
	parameter int STATES = 7
)
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [5:0] readyIn,
	input wire logic [2:0] fifoFlags,
	input wire logic countExpired,
	input wire logic [DATA_WIDTH-1:0] dataIn,
	output logic [DATA_WIDTH-1:0] dataOut,
	output logic dataOe_n,
	output logic [DATA_WIDTH-1:0] readData,
	output logic readStrobe,
	output logic [5:0] ctlOut,
	output logic [5:0] ctlOe_n,
	output logic [8:0] addressOutput,
	output logic fifoAdvance,
	output logic waveformDoneIrq,
	output logic stateIrq
);
	logic [7:0] idleStatus_q;
	logic [7:0] idleCtl_q;
	logic [7:0] ctlCfg_q;
	logic doneIe_q;
	logic intReady_q;
	logic readMode_q;
	logic [31:0] prog_q [STATES];
	logic [2:0] state_q;
	logic [8:0] count_q;
	logic done;
	logic [31:0] instr;
	logic [7:0] lenField;
	logic [7:0] opField;
	logic [7:0] logicField;
	logic [7:0] outField;
	logic isDecision;
	logic termA;
	logic termB;
	logic decide;
	logic [2:0] target;
	logic stateEnd;
	logic [2:0] nextState;
	logic entry;
	logic runTask;
	logic [7:0] termVec;
	logic dphValid_q;
	logic dphWrite_q;
	logic [11:0] dphAddr_q;
	logic addrPhase;
	logic wrIdleStatus;
	logic wrIdleCtl;
	logic wrCtlCfg;
	logic wrTrigger;
	logic wrAbort;
	logic wrDoneIe;
	logic wrIntReady;
	logic trigger;
	logic abortReq;
	logic entry_q;

	// Zero-wait slave: every access completes in its first data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrPhase = hsel && hready && htrans[1];

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dphValid_q <= 1'b0;
			dphWrite_q <= 1'b0;
			dphAddr_q <= 12'h000;
		end
		else if (clkEn)
		begin
			dphValid_q <= addrPhase;
			dphWrite_q <= addrPhase && hwrite;
			dphAddr_q <= haddr[11:0];
		end
	end

	assign wrIdleStatus = dphWrite_q && dphAddr_q == `WSS_OFF_IDLE_STATUS;
	assign wrIdleCtl = dphWrite_q && dphAddr_q == `WSS_OFF_IDLE_CTL;
	assign wrCtlCfg = dphWrite_q && dphAddr_q == `WSS_OFF_CTL_CFG;
	assign wrTrigger = dphWrite_q && dphAddr_q == `WSS_OFF_TRIGGER;
	assign wrAbort = dphWrite_q && dphAddr_q == `WSS_OFF_ABORT;
	assign wrDoneIe = dphWrite_q && dphAddr_q == `WSS_OFF_DONE_IE;
	assign wrIntReady = dphWrite_q && dphAddr_q == `WSS_OFF_INT_READY;
	// Trigger while busy is ignored; firmware must wait for done
	assign trigger = wrTrigger && done; // see [R3]
	assign abortReq = wrAbort && !done; // see [R6]

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			idleStatus_q <= 8'h00;
			idleCtl_q <= `WSS_RST_IDLE_CTL;
			ctlCfg_q <= 8'h00;
			doneIe_q <= 1'b0;
			intReady_q <= 1'b0;
			readMode_q <= 1'b0;
		end
		else if (clkEn)
		begin
			// Config writes except internal ready land only when idle; other busy-time writes except abort are dropped
			if (done) // see [R7]
			begin
				if (wrIdleStatus)
					idleStatus_q <= hwdata[7:0];
				if (wrIdleCtl)
					idleCtl_q <= hwdata[7:0];
				if (wrCtlCfg)
					ctlCfg_q <= hwdata[7:0];
				if (wrDoneIe)
					doneIe_q <= hwdata[0];
				if (trigger)
					readMode_q <= hwdata[0];
			end
			if (wrIntReady)
				intReady_q <= hwdata[0];
		end
	end

	for (genvar gi = 0; gi < STATES; gi++)
	begin : g_prog
		always_ff @(posedge mclk or negedge arst_n)
		begin
			if (!arst_n)
				prog_q[gi] <= 32'h0000_0000;
			else if (clkEn && done && dphWrite_q
				&& dphAddr_q == `WSS_OFF_PROGRAM + 12'(gi * 4)) // see [R13]
				prog_q[gi] <= hwdata;
		end
	end

	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (dphValid_q)
		begin
			unique case (dphAddr_q)
				`WSS_OFF_IDLE_STATUS: hrdata = {24'h0, done, idleStatus_q[6:0]}; // see [R4]
				`WSS_OFF_IDLE_CTL: hrdata = {24'h0, idleCtl_q};
				`WSS_OFF_CTL_CFG: hrdata = {24'h0, ctlCfg_q};
				`WSS_OFF_TRIGGER: hrdata = {24'h0, done, 6'h0, readMode_q}; // see [R4]
				`WSS_OFF_DONE_IE: hrdata = {31'h0, doneIe_q};
				`WSS_OFF_INT_READY: hrdata = {31'h0, intReady_q};
				default:
				begin
					for (int i = 0; i < STATES; i++)
						if (dphAddr_q == `WSS_OFF_PROGRAM + 12'(i * 4))
							hrdata = prog_q[i];
				end
			endcase
		end
	end

	assign done = state_q == `WSS_IDLE_INDEX; // see [R2]
	assign instr = done ? 32'h0 : prog_q[state_q]; // see [R1]
	assign lenField = instr[31:24];
	assign opField = instr[23:16];
	assign logicField = instr[15:8];
	assign outField = instr[7:0];
	assign isDecision = opField[`WSS_BIT_DECISION];

	// Count expired replaces ready input five
	assign termVec = {intReady_q, 1'b0, countExpired, readyIn[4:0]}; // see [R20]
	always_comb
	begin
		termA = logicField[5:3] == 3'h6 ? fifoFlags[0] : termVec[logicField[5:3]];
		termB = logicField[2:0] == 3'h6 ? fifoFlags[0] : termVec[logicField[2:0]];
		if (logicField[5:3] == 3'h6 || logicField[2:0] == 3'h6)
		begin
			if (logicField[5:3] == 3'h6)
				termA = |(fifoFlags & 3'h7) && fifoFlags != 3'h0 ? fifoFlags[0] | fifoFlags[1]
					| fifoFlags[2] : 1'b0;
			if (logicField[2:0] == 3'h6)
				termB = fifoFlags[0] | fifoFlags[1] | fifoFlags[2];
		end
		unique case (wss_pkg::wss_lfunc_type'({logicField[`WSS_BIT_LFUNC+1],
			logicField[`WSS_BIT_LFUNC]}))
			wss_pkg::WSS_LF_AND: decide = termA & termB; // see [R21]
			wss_pkg::WSS_LF_OR: decide = termA | termB;
			wss_pkg::WSS_LF_XOR: decide = termA ^ termB;
			default: decide = termA & termB;
		endcase
	end

	assign target = decide ? lenField[5:3] : lenField[2:0]; // see [R18]
	// Decision resolves after exactly one cycle in the state
	assign stateEnd = isDecision ? 1'b1 : count_q == 9'h001; // see [R22] see [R15]

	always_comb
	begin
		nextState = state_q;
		if (abortReq)
			nextState = `WSS_IDLE_INDEX; // see [R6]
		else if (done)
			nextState = trigger ? 3'h0 : state_q;
		else if (stateEnd)
		begin
			if (isDecision)
				nextState = target;
			else if (state_q == 3'(STATES - 1))
				nextState = `WSS_IDLE_INDEX; // see [R16]
			else
				nextState = state_q + 3'h1; // see [R17]
		end
	end

	assign entry = clkEn && nextState != `WSS_IDLE_INDEX && (nextState != state_q || done);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= `WSS_IDLE_INDEX; // see [R25]
			count_q <= 9'h001;
			entry_q <= 1'b0;
		end
		else if (clkEn)
		begin
			state_q <= nextState; // see [R23]
			entry_q <= entry || (!done && !abortReq && isDecision && stateEnd
				&& target == state_q);
			if (nextState != `WSS_IDLE_INDEX)
			begin
				if (nextState != state_q || done || stateEnd)
				begin
					// Duration zero stretches to 256 cycles
					if (prog_q[nextState][31:24] == 8'h00)
						count_q <= `WSS_LEN_ZERO_CYCLES; // see [R24]
					else
						count_q <= {1'b0, prog_q[nextState][31:24]};
				end
				else
					count_q <= count_q - 9'h001;
			end
		end
	end

	logic stateEntryLoop;
	logic [2:0] prevState_q;
	// Self-loop of a decision state repeats its task only with re-execute
	assign runTask = clkEn && entry_q && !done
		&& (!isDecision || lenField[`WSS_BIT_REEXEC] || !stateEntryLoop); // see [R19]
	assign stateEntryLoop = prevState_q == state_q;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			prevState_q <= `WSS_IDLE_INDEX;
		else if (clkEn)
			prevState_q <= state_q;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fifoAdvance <= 1'b0;
			stateIrq <= 1'b0;
			readStrobe <= 1'b0;
			waveformDoneIrq <= 1'b0;
		end
		else if (clkEn)
		begin
			fifoAdvance <= runTask && opField[`WSS_BIT_NEXT];
			stateIrq <= runTask && opField[`WSS_BIT_GINT];
			readStrobe <= runTask && readMode_q && opField[`WSS_BIT_DATA]; // see [R14]
			waveformDoneIrq <= doneIe_q && !done && nextState == `WSS_IDLE_INDEX; // see [R5]
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			addressOutput <= 9'h000;
		else if (clkEn && runTask && opField[`WSS_BIT_INCAD])
			addressOutput <= addressOutput + 9'h001; // see [R19]
	end

	// Read data holds the last sample until the next sampling state
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			readData <= '0;
		else if (clkEn && runTask && readMode_q && opField[`WSS_BIT_DATA])
			readData <= dataIn; // see [R14]
	end

	// Idle drive shows this word until a later trigger reloads it
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			dataOut <= '0;
		else if (clkEn && wrTrigger && done && hwdata[1])
			dataOut <= hwdata[DATA_WIDTH+15:16]; // see [R8]
	end

	always_comb
	begin
		if (done)
			dataOe_n = !idleStatus_q[`WSS_BIT_IDLE_DRIVE]; // see [R8]
		else
			dataOe_n = readMode_q || !opField[`WSS_BIT_DATA]; // see [R14]
	end

	logic [7:0] ctlSrc;
	assign ctlSrc = done ? idleCtl_q : outField;
	always_comb
	begin
		if (ctlCfg_q[`WSS_BIT_TRISTATE_MODE]) // see [R9]
		begin
			ctlOut = {2'b00, ctlSrc[3:0]};
			ctlOe_n = {2'b11, ~ctlSrc[7:4]}; // see [R12]
		end
		else
		begin
			ctlOut = ctlSrc[5:0]; // see [R10] see [R15]
			// Open-drain outputs release the pin for a high level
			ctlOe_n = ctlCfg_q[5:0] & ctlSrc[5:0]; // see [R11]
		end
	end
endmodule : wss_sequencer
`default_nettype wire

// ===== pkg/wss_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the waveform sequencer
// Assumes: 32-bit AHB-Lite register words
// Notes: Included by the sequencer module, the port checker and the bench
`ifndef WSS_DEFINES_SVH
`define WSS_DEFINES_SVH
`define WSS_OFF_IDLE_STATUS 12'h000
`define WSS_OFF_IDLE_CTL 12'h004
`define WSS_OFF_CTL_CFG 12'h008
`define WSS_OFF_TRIGGER 12'h00C
`define WSS_OFF_ABORT 12'h010
`define WSS_OFF_DONE_IE 12'h014
`define WSS_OFF_INT_READY 12'h018
`define WSS_OFF_PROGRAM 12'h040
`define WSS_BIT_DONE 7
`define WSS_BIT_IDLE_DRIVE 0
`define WSS_BIT_TRISTATE_MODE 7
`define WSS_BIT_DECISION 0
`define WSS_BIT_DATA 1
`define WSS_BIT_NEXT 2
`define WSS_BIT_INCAD 3
`define WSS_BIT_GINT 4
`define WSS_BIT_REEXEC 7
`define WSS_BIT_LFUNC 6
`define WSS_IDLE_INDEX 3'h7
`define WSS_LEN_ZERO_CYCLES 9'h100
`define WSS_RST_IDLE_CTL 8'hFF
`endif

// ===== pkg/wss_pkg.sv
// Purpose: Types of the waveform sequencer
// Assumes: Nothing beyond the defines header
// Notes: Logic function codes follow the instruction field
`default_nettype none
package wss_pkg;
	typedef enum logic [1:0]
	{
		WSS_LF_AND = 2'h0,
		WSS_LF_OR = 2'h1,
		WSS_LF_XOR = 2'h2,
		WSS_LF_RSV = 2'h3
	} wss_lfunc_type;
	typedef enum logic [1:0]
	{
		WSS_BUS_IDLE,
		WSS_BUS_WRITE,
		WSS_BUS_READ
	} wss_bus_type;
endpackage : wss_pkg
`default_nettype wire

// ===== verification/wss_sequencer_props.sv
// Purpose: Port checker of the waveform sequencer
// Assumes: Control config written only while idle
// Notes: Shadows two config registers from bus writes
`timescale 1ns/100ps
`default_nettype none
`include "wss_defines.svh"
module wss_sequencer_props #(
	parameter int DATA_WIDTH = 16
)
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [DATA_WIDTH-1:0] dataIn,
	input wire logic dataOe_n,
	input wire logic [DATA_WIDTH-1:0] readData,
	input wire logic readStrobe,
	input wire logic [5:0] ctlOut,
	input wire logic [5:0] ctlOe_n,
	input wire logic [8:0] addressOutput,
	input wire logic waveformDoneIrq
);
	logic wPend_q;
	logic [11:0] wAdr_q;
	logic [7:0] cfg_q;
	logic [7:0] idle_q;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			wPend_q <= 1'b0;
		else
			wPend_q <= hsel & hready & htrans[1] & hwrite;
	end
	always_ff @(posedge mclk)
	begin
		wAdr_q <= haddr[11:0];
	end
	// Shadows lag nothing: the design takes the write at the same edge
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg_q <= 8'h00;
			idle_q <= `WSS_RST_IDLE_CTL;
		end
		else if (wPend_q && wAdr_q == `WSS_OFF_CTL_CFG)
			cfg_q <= hwdata[7:0];
		else if (wPend_q && wAdr_q == `WSS_OFF_IDLE_CTL)
			idle_q <= hwdata[7:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_abortWr;
		wPend_q && wAdr_q == `WSS_OFF_ABORT && cfg_q == 8'h00;
	endsequence
	sequence s_idleCtl;
		ctlOut == idle_q[5:0] && ctlOe_n == 6'h00;
	endsequence
	property p_resetIdle;
		$rose(arst_n) |-> ctlOut == 6'h3F && ctlOe_n == 6'h00 && dataOe_n;
	endproperty
	property p_donePulse;
		waveformDoneIrq |=> !waveformDoneIrq;
	endproperty
	property p_sample;
		readStrobe |-> readData == $past(dataIn);
	endproperty
	property p_noDriveOnRead;
		readStrobe |-> dataOe_n;
	endproperty
	property p_mode1;
		cfg_q[7] |-> ctlOe_n[5:4] == 2'h3;
	endproperty
	property p_abort;
		s_abortWr |-> ##[1:2] s_idleCtl;
	endproperty
	property p_doneIdle;
		waveformDoneIrq && cfg_q == 8'h00 |-> s_idleCtl;
	endproperty
	property p_addrStep;
		addressOutput != $past(addressOutput) |-> addressOutput == $past(addressOutput) + 9'h001;
	endproperty
	a_resetIdle: assert property (p_resetIdle) else $error("idle outputs wrong after reset");
	a_donePulse: assert property (p_donePulse) else $error("done pulse too long");
	a_sample: assert property (p_sample) else $error("stored data wrong");
	a_noDriveOnRead: assert property (p_noDriveOnRead) else $error("bus driven on read");
	a_mode1: assert property (p_mode1) else $error("outputs 4 5 enabled");
	a_abort: assert property (p_abort) else $error("abort left engine busy");
	a_doneIdle: assert property (p_doneIdle) else $error("done without idle");
	a_addrStep: assert property (p_addrStep) else $error("address jump");
endmodule : wss_sequencer_props
bind wss_sequencer wss_sequencer_props #(.DATA_WIDTH(DATA_WIDTH)) propsChk (.*);
`default_nettype wire

// ===== verification/wss_peripheral.sv
// Purpose: Peripheral model at the far side of the sequencer
// Assumes: Control output 0 is its active low strobe
// Notes: Data changes every cycle so a stale sample shows
`timescale 1ns/100ps
`default_nettype none
module wss_peripheral #(
	parameter int LAT = 5
)
(
	input wire logic mclk,
	input wire logic [5:0] ctlWire,
	output logic [5:0] readyIn,
	output logic [15:0] dataIn
);
	int n = 0;
	logic rdy = 1'b0;
	logic [15:0] dataWord = 16'hA000;
	assign readyIn = {5'h00, rdy};
	assign dataIn = dataWord;
	// Ready comes LAT+1 cycles into the strobe and drops one cycle after it ends
	always @(posedge mclk)
	begin
		dataWord <= dataWord + 16'h0001;
		n <= ctlWire[0] ? 0 : n + 1;
		rdy <= !ctlWire[0] && n >= LAT;
	end
endmodule : wss_peripheral
`default_nettype wire

// ===== verification/wss_sequencer_tb.sv
// Purpose: Self-checking bench of the waveform sequencer
// Assumes: Zero-wait slave, one master
// Notes: Config cases run from a table
`timescale 1ns/100ps
`default_nettype none
`include "wss_defines.svh"
module wss_sequencer_tb;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic clkEn = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [2:0] fifoFlags = 3'h0;
	logic countExpired = 1'b0;
	logic hready, hreadyout, hresp, dataOe_n, readStrobe, fifoAdvance, waveformDoneIrq, stateIrq;
	logic [31:0] hrdata;
	logic [5:0] readyIn, ctlOut, ctlOe_n, ctlWire;
	logic [15:0] dataIn, dataOut, readData;
	logic [8:0] addressOutput, dA;
	logic [31:0] r;
	logic f;
	int miscompares = 0;
	int tests_run = 0;
	int lowCnt = 0;
	int strobes = 0;
	int irqs = 0;
	int adv = 0;
	int sirq = 0;
	int low;
	int i0;
	// Rows: config, idle levels, expected enables_n, expected wire with pull-up
	logic [31:0] rows [5] = '{32'h002A_002A, 32'h0100_0000, 32'h0101_0101,
		32'h805A_3A3A, 32'h00FF_003F};
	// Rows: branch byte, opcode, logic byte, trigger
	logic [31:0] dec [5] = '{32'hB809_0000, 32'h3809_0000, 32'h3809_4700,
		32'h3809_8700, 32'h381F_3501};
	assign hready = hreadyout;
	assign ctlWire = ctlOe_n | ctlOut;
	always #20 mclk = ~mclk;
	wss_sequencer dut (.*);
	wss_peripheral peer (.*);
	always @(negedge mclk)
	begin
		lowCnt += (ctlWire[0] === 1'b0);
		strobes += (readStrobe === 1'b1);
		irqs += (waveformDoneIrq === 1'b1);
		adv += (fifoAdvance === 1'b1);
		sirq += (stateIrq === 1'b1);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge mclk);
		while (hready !== 1'b1)
			@(posedge mclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge mclk);
		while (hready !== 1'b1)
			@(posedge mclk);
		q = hrdata;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0000_0000, q);
	endtask : rd
	// Counts strobe-low cycles and address steps across one waveform
	task automatic run(input logic [31:0] t);
		int l0;
		logic [8:0] a0;
		l0 = lowCnt;
		a0 = addressOutput;
		wr(`WSS_OFF_TRIGGER, t);
		rd(`WSS_OFF_IDLE_STATUS, r);
		f = r[7];
		while (r[7] !== 1'b1)
			rd(`WSS_OFF_IDLE_STATUS, r);
		low = lowCnt - l0;
		dA = addressOutput - a0;
	endtask : run
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		#200000;
		miscompares++;
		test_done();
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rd(`WSS_OFF_IDLE_STATUS, r);
		chk(32'(r[7]), 32'h1);
		chk(32'({ctlWire, ctlOe_n, dataOe_n}), 32'h1F81);
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(`WSS_OFF_CTL_CFG, 32'(rows[i][31:24]));
			wr(`WSS_OFF_IDLE_CTL, 32'(rows[i][23:16]));
			rd(`WSS_OFF_IDLE_CTL, r);
			chk(32'(r[7:0]), 32'(rows[i][23:16]));
			chk(32'(ctlOe_n), 32'(rows[i][13:8]));
			chk(32'(ctlWire), 32'(rows[i][5:0]));
		end
		$display("idle output test done");
		wr(`WSS_OFF_DONE_IE, 32'h0000_0001);
		wr(`WSS_OFF_INT_READY, 32'h0000_0001);
		wr(`WSS_OFF_IDLE_STATUS, 32'h0000_0001);
		// All seven fixed states; state 2 uses length zero
		for (int i = 0; i < 7; i++)
			wr(12'(`WSS_OFF_PROGRAM + 4 * i), i == 2 ? 32'h0002_003E :
				i == 1 ? 32'h0202_003F : 32'h0200_003F);
		i0 = irqs;
		run(32'h1234_0002);
		chk(32'(f), 32'h0);
		chk(32'(low), 32'd256);
		chk(32'(irqs - i0), 32'h1);
		chk(32'({dataOe_n, dataOut}), 32'h0000_1234);
		wr(`WSS_OFF_IDLE_STATUS, 32'h0000_0000);
		// The write lands at the edge that ends the task; look one edge later
		@(posedge mclk);
		chk(32'(dataOe_n), 32'h1);
		$display("fixed state test done");
		countExpired <= 1'b1;
		fifoFlags <= 3'h4;
		foreach (dec[i])
		begin
			wr(`WSS_OFF_PROGRAM, {dec[i][31:8], 8'h3E});
			run(32'(dec[i][7:0]));
			chk(32'(dec[i][15:8] == 8'h00 ? low > 5 : low == 1), 32'h1);
			chk(32'(dA), dec[i][31] ? 32'(low) : 32'h1);
		end
		chk(32'(strobes > 0), 32'h1);
		chk(32'(adv), 32'h1);
		chk(32'(sirq), 32'h1);
		$display("decision test done");
		countExpired <= 1'b0;
		wr(`WSS_OFF_PROGRAM, 32'h3801_2D3E);
		wr(`WSS_OFF_TRIGGER, 32'h0000_0000);
		repeat (20) @(posedge mclk);
		chk(32'(ctlWire[0]), 32'h0);
		wr(`WSS_OFF_ABORT, 32'h0000_0001);
		rd(`WSS_OFF_IDLE_STATUS, r);
		chk(32'(r[7]), 32'h1);
		chk(32'(ctlWire), 32'h3F);
		$display("abort test done");
		test_done();
	end
endmodule : wss_sequencer_tb
`default_nettype wire
